// ==== shared/rgc_consts.vh ====
// constants for the remote gauge control input block
`ifndef RGC_CONSTS_VH
`define RGC_CONSTS_VH

// debounce time in microseconds and clock rate in kHz
`define RGC_DEBOUNCE_US  50000
`define RGC_CLK_KHZ      100000
// cycles of debounce: 50 ms at 100 MHz
`define RGC_DEBOUNCE_CYC ((`RGC_DEBOUNCE_US * `RGC_CLK_KHZ) / 1000)
// reset level of every debounced line: open inputs read high
`define RGC_IDLE_LEVEL   1'b1
// default outgas duration in cycles (one second)
`define RGC_DEGAS_CYC    100000000
// input line indices
`define RGC_L_ION1       0
`define RGC_L_ION2       1
`define RGC_L_DEGAS      2
`define RGC_L_INTLK      3
`define RGC_L_KEYLK      4
`define RGC_L_PIR1       5
`define RGC_L_PIR2       6
`define RGC_L_LOGW       7
`define RGC_L_GATE       8
`define RGC_L_FIL1       9
`define RGC_L_FIL2       10
`define RGC_L_PANEL      11
`define RGC_NLINES       12

`endif

// ==== rtl/rgc_debounce.v ====
// one input line debouncer with qualified edge pulses
`timescale 1ns/100ps
`default_nettype none
`include "rgc_consts.vh"

module rgc_debounce
#(
  parameter CNT_W = 23,
  parameter [CNT_W-1:0] TERM = 23'd5000000
)
(
  // clock and reset
  input  wire i_ref_clk,
  input  wire i_rst,
  // raw line
  input  wire i_line,
  // debounced level and validated edges
  output reg  o_level,
  output reg  o_fall,
  output reg  o_rise
);

  reg             samp_r;
  reg [CNT_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // debounce counter
  // ----------------------------------------------------------------
  // the level before any accepted change, except the reset level, is itself a stable level held
  // for the full time, so an accepted edge other than the first after reset had the old level
  // stable for the debounce time as well
  always @(posedge i_ref_clk)
  begin
    o_fall <= 1'b0;
    o_rise <= 1'b0;
    if (i_rst)
    begin
      samp_r  <= `RGC_IDLE_LEVEL;
      o_level <= `RGC_IDLE_LEVEL;
      cnt_r   <= {CNT_W{1'b0}};
    end
    else
    begin
      samp_r <= i_line;
      if (samp_r != i_line)
        cnt_r <= {CNT_W{1'b0}};
      else if (samp_r != o_level)
      begin
        if (cnt_r == TERM - 1'b1)
        begin
          o_level <= samp_r;
          o_fall  <= ~samp_r;
          o_rise  <= samp_r;
          cnt_r   <= {CNT_W{1'b0}};
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
      else
        cnt_r <= {CNT_W{1'b0}};
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rgc_remote_inputs.v ====
// remote gauge control inputs: debounce and command decode
`timescale 1ns/100ps
`default_nettype none
`include "rgc_consts.vh"


module rgc_remote_inputs
#(
  parameter DEB_CYC   = `RGC_DEBOUNCE_CYC,
  parameter DEGAS_CYC = `RGC_DEGAS_CYC,
  parameter CNT_W     = 23,
  parameter DG_W      = 27
)
(
  // clock and reset
  input  wire i_ref_clk,
  input  wire i_rst,
  // remote lines, raw, high when open
  input  wire i_ion_gauge_request_one,
  input  wire i_ion_gauge_request_two,
  input  wire i_outgas_request,
  input  wire i_emission_interlock,
  input  wire i_gauge_keypad_lock,
  input  wire i_pirani_power_down_one,
  input  wire i_pirani_power_down_two,
  input  wire i_log_wipe,
  input  wire i_remote_gate,
  input  wire i_filament_select_one,
  input  wire i_filament_select_two,
  input  wire i_panel_lock,
  // gauge conditions from the measurement side
  input  wire i_ion_one_pressure_ok,
  input  wire i_ion_two_pressure_ok,
  input  wire i_ion_one_degas_ok,
  input  wire i_ion_two_degas_ok,
  // local front panel and computer requests, one-cycle pulses
  input  wire i_key_ion_one,
  input  wire i_key_ion_two,
  input  wire i_key_degas,
  input  wire i_key_auto,
  input  wire i_host_ion_one_on,
  input  wire i_host_ion_two_on,
  input  wire i_touch,
  // gauge state
  output reg  o_ion_gauge_one_on,
  output reg  o_ion_gauge_two_on,
  output reg  o_degas_active,
  output reg  o_filament_one_sel,
  output reg  o_filament_two_sel,
  output reg  o_pirani_one_on,
  output reg  o_pirani_two_on,
  // commands and gated front panel events
  output reg  o_log_clear,
  output reg  o_key_auto,
  output reg  o_touch,
  // debounced lock levels
  output reg  o_keypad_enabled,
  output reg  o_panel_enabled,
  output reg  o_remote_enabled
);

  wire [`RGC_NLINES-1:0] raw;
  wire [`RGC_NLINES-1:0] lvl;
  wire [`RGC_NLINES-1:0] fall;
  wire [`RGC_NLINES-1:0] rise;

  assign raw = {i_panel_lock, i_filament_select_two,
                i_filament_select_one, i_remote_gate, i_log_wipe,
                i_pirani_power_down_two, i_pirani_power_down_one,
                i_gauge_keypad_lock, i_emission_interlock,
                i_outgas_request, i_ion_gauge_request_two,
                i_ion_gauge_request_one};

  // ----------------------------------------------------------------
  // debouncers, one per line
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RGC_NLINES; g = g + 1)
    begin : deb
      rgc_debounce
      #(
        .CNT_W (CNT_W),
        .TERM  (DEB_CYC[CNT_W-1:0])
      )
      u_deb
      (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_line    (raw[g]),
        .o_level   (lvl[g]),
        .o_fall    (fall[g]),
        .o_rise    (rise[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // qualifying terms
  // ----------------------------------------------------------------
  // edges are used only in their validation cycle, never stored
  wire gate_ok  = ~lvl[`RGC_L_GATE];
  wire intlk_ok = lvl[`RGC_L_INTLK];
  wire keys_ok  = lvl[`RGC_L_KEYLK];

  wire rem_on1  = gate_ok & fall[`RGC_L_ION1];
  wire rem_on2  = gate_ok & fall[`RGC_L_ION2];
  wire rem_off1 = gate_ok & rise[`RGC_L_ION1];
  wire rem_off2 = gate_ok & rise[`RGC_L_ION2];

  wire key_on1  = keys_ok & i_key_ion_one;
  wire key_on2  = keys_ok & i_key_ion_two;

  // remote requests need pressure and interlock, local ones interlock
  wire req1 = intlk_ok & ((rem_on1 & i_ion_one_pressure_ok) |
              key_on1 | i_host_ion_one_on);
  wire req2 = intlk_ok & ((rem_on2 & i_ion_two_pressure_ok) |
              key_on2 | i_host_ion_two_on);

  wire fil1_nxt = (o_filament_one_sel | (gate_ok &
                  fall[`RGC_L_FIL1])) &
                  ~(gate_ok & rise[`RGC_L_FIL1]);
  wire fil2_nxt = (o_filament_two_sel | (gate_ok &
                  fall[`RGC_L_FIL2])) &
                  ~(gate_ok & rise[`RGC_L_FIL2]);
  wire no_fil   = ~fil1_nxt & ~fil2_nxt;

  reg ion1_nxt;
  reg ion2_nxt;

  // ----------------------------------------------------------------
  // gauge on/off decisions
  // ----------------------------------------------------------------
  // a simultaneous request for both gauges favours gauge one
  always @*
  begin
    ion1_nxt = o_ion_gauge_one_on;
    ion2_nxt = o_ion_gauge_two_on;
    if (rem_off1)
      ion1_nxt = 1'b0;
    if (rem_off2)
      ion2_nxt = 1'b0;
    if (req2)
    begin
      ion2_nxt = 1'b1;
      ion1_nxt = 1'b0;
    end
    if (req1)
    begin
      ion1_nxt = 1'b1;
      ion2_nxt = 1'b0;
    end
    if (no_fil)
    begin
      ion1_nxt = 1'b0;
      ion2_nxt = 1'b0;
    end
    if (~intlk_ok)
    begin
      ion1_nxt = 1'b0;
      ion2_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // degas control
  // ----------------------------------------------------------------
  reg [DG_W-1:0] dg_cnt_r;

  wire active_ok = (o_ion_gauge_one_on & i_ion_one_degas_ok) |
                   (o_ion_gauge_two_on & i_ion_two_degas_ok);
  wire dg_start  = (gate_ok & fall[`RGC_L_DEGAS]) |
                   (keys_ok & i_key_degas);
  wire dg_abort  = (gate_ok & rise[`RGC_L_DEGAS]) |
                   ~(ion1_nxt | ion2_nxt) |
                   ~intlk_ok;
  wire dg_done   = (dg_cnt_r == DEGAS_CYC[DG_W-1:0] - 1'b1);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_ion_gauge_one_on <= 1'b0;
      o_ion_gauge_two_on <= 1'b0;
      o_degas_active     <= 1'b0;
      dg_cnt_r           <= {DG_W{1'b0}};
      o_filament_one_sel <= 1'b1;
      o_filament_two_sel <= 1'b0;
      o_pirani_one_on    <= 1'b1;
      o_pirani_two_on    <= 1'b1;
      o_log_clear        <= 1'b0;
      o_key_auto         <= 1'b0;
      o_touch            <= 1'b0;
      o_keypad_enabled   <= `RGC_IDLE_LEVEL;
      o_panel_enabled    <= `RGC_IDLE_LEVEL;
      o_remote_enabled   <= 1'b0;
    end
    else
    begin
      o_ion_gauge_one_on <= ion1_nxt;
      o_ion_gauge_two_on <= ion2_nxt;
      o_filament_one_sel <= fil1_nxt;
      o_filament_two_sel <= fil2_nxt;
      if (o_degas_active)
      begin
        if (dg_abort | dg_done)
        begin
          o_degas_active <= 1'b0;
          dg_cnt_r       <= {DG_W{1'b0}};
        end
        else
          dg_cnt_r <= dg_cnt_r + 1'b1;
      end
      else if (dg_start & active_ok & intlk_ok & ~dg_abort)
      begin
        o_degas_active <= 1'b1;
        dg_cnt_r       <= {DG_W{1'b0}};
      end
      if (fall[`RGC_L_PIR1])
        o_pirani_one_on <= 1'b0;
      else if (rise[`RGC_L_PIR1])
        o_pirani_one_on <= 1'b1;
      if (fall[`RGC_L_PIR2])
        o_pirani_two_on <= 1'b0;
      else if (rise[`RGC_L_PIR2])
        o_pirani_two_on <= 1'b1;
      o_log_clear      <= fall[`RGC_L_LOGW];
      o_key_auto       <= keys_ok & i_key_auto;
      o_touch          <= lvl[`RGC_L_PANEL] & i_touch;
      o_keypad_enabled <= keys_ok;
      o_panel_enabled  <= lvl[`RGC_L_PANEL];
      o_remote_enabled <= gate_ok;
    end
  end

endmodule
`default_nettype wire

// ==== tb/rgc_contacts.sv ====
// relay contact model driving the raw remote lines
`timescale 1ns/100ps
`default_nettype none
module rgc_contacts
(
  // closure per line, then raw lines
  input  wire logic [11:0] i_close,
  output wire logic [11:0] o_line
);
  // open contact floats to the pull-up
  assign o_line = ~i_close;
endmodule
`default_nettype wire

// ==== tb/rgc_chk_assertions.sv ====
// assertion checker for the remote gauge control inputs
`timescale 1ns/100ps
`default_nettype none
module rgc_chk
#(parameter DEB_CYC = 8, parameter DEGAS_CYC = 40)
(
  // watched ports
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_emission_interlock,
  input wire logic i_remote_gate,
  input wire logic i_touch,
  input wire logic o_ion_gauge_one_on,
  input wire logic o_ion_gauge_two_on,
  input wire logic o_degas_active,
  input wire logic o_filament_one_sel,
  input wire logic o_filament_two_sel,
  input wire logic o_log_clear,
  input wire logic o_touch,
  input wire logic o_panel_enabled,
  input wire logic o_remote_enabled
);
  // ----
  // properties
  // ----
  localparam int DG_MAX = DEGAS_CYC + 3;
  reg  [7:0] il_cnt_r;
  wire       gon = o_ion_gauge_one_on | o_ion_gauge_two_on;
  always @(posedge i_ref_clk)
    il_cnt_r <= (i_rst | i_emission_interlock) ? 8'h00 :
                il_cnt_r + {7'h00, ~&il_cnt_r};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_one; !(o_ion_gauge_one_on && o_ion_gauge_two_on); endproperty
  a_one: assert property (p_one)
    else $error("two gauges on");
  property p_ilk; il_cnt_r > DEB_CYC + 5 |-> !gon && !o_degas_active;
  endproperty
  a_ilk: assert property (p_ilk)
    else $error("interlock ignored");
  property p_dgg; o_degas_active |-> $past(gon); endproperty
  a_dgg: assert property (p_dgg)
    else $error("degas without gauge");
  property p_dgl; $rose(o_degas_active) |-> ##[1:DG_MAX] !o_degas_active;
  endproperty
  a_dgl: assert property (p_dgl)
    else $error("degas too long");
  property p_gate;
    $rose(o_remote_enabled) |-> !$past(i_remote_gate, DEB_CYC);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate taken early");
  property p_fil;
    (!o_filament_one_sel && !o_filament_two_sel)[*2] |-> !gon;
  endproperty
  a_fil: assert property (p_fil)
    else $error("gauge on without filament");
  property p_log; o_log_clear |=> !o_log_clear; endproperty
  a_log: assert property (p_log)
    else $error("log clear too long");
  property p_tch;
    o_touch |-> $past(i_touch) && ($past(o_panel_enabled) || o_panel_enabled);
  endproperty
  a_tch: assert property (p_tch)
    else $error("touch passed while locked");
  c_dg: cover property ($rose(o_degas_active));
  c_lg: cover property (o_log_clear);
  c_g2: cover property (o_ion_gauge_two_on);
endmodule
bind rgc_remote_inputs rgc_chk #(.DEB_CYC(DEB_CYC), .DEGAS_CYC(DEGAS_CYC))
  u_chk (.i_ref_clk, .i_rst, .i_emission_interlock, .i_remote_gate, .i_touch,
  .o_ion_gauge_one_on, .o_ion_gauge_two_on, .o_degas_active, .o_log_clear,
  .o_filament_one_sel, .o_filament_two_sel, .o_touch, .o_panel_enabled,
  .o_remote_enabled);
`default_nettype wire

// ==== tb/remote_gauge_control_inputs_bench.sv ====
// self-checking bench for the remote gauge control inputs
`timescale 1ns/100ps
`default_nettype none
module remote_gauge_control_inputs_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] cl_r = 12'h000;
  reg  [3:0]  ok_r = 4'hf;
  reg  [6:0]  pv_r = 7'h00;
  wire [11:0] ln;
  wire [12:0] q;
  int         error_cnt = 0;
  int         checks = 0;
  int         cyc_n = 0;
  int         lcnt = 0;
  int         kcnt = 0;
  int         tcnt = 0;
  always #5 clk = ~clk;
  rgc_contacts u_far (.i_close(cl_r), .o_line(ln));
  rgc_remote_inputs #(.DEB_CYC(8), .DEGAS_CYC(40)) uut (
    .i_ref_clk(clk), .i_rst(rst),
    .i_ion_gauge_request_one(ln[0]), .i_ion_gauge_request_two(ln[1]),
    .i_outgas_request(ln[2]), .i_emission_interlock(ln[3]),
    .i_gauge_keypad_lock(ln[4]), .i_pirani_power_down_one(ln[5]),
    .i_pirani_power_down_two(ln[6]), .i_log_wipe(ln[7]),
    .i_remote_gate(ln[8]), .i_filament_select_one(ln[9]),
    .i_filament_select_two(ln[10]), .i_panel_lock(ln[11]),
    .i_ion_one_pressure_ok(ok_r[0]), .i_ion_two_pressure_ok(ok_r[1]),
    .i_ion_one_degas_ok(ok_r[2]), .i_ion_two_degas_ok(ok_r[3]),
    .i_key_ion_one(pv_r[0]), .i_key_ion_two(pv_r[1]), .i_key_degas(pv_r[2]),
    .i_key_auto(pv_r[3]), .i_host_ion_one_on(pv_r[4]),
    .i_host_ion_two_on(pv_r[5]), .i_touch(pv_r[6]),
    .o_ion_gauge_one_on(q[0]), .o_ion_gauge_two_on(q[1]),
    .o_degas_active(q[2]), .o_filament_one_sel(q[3]),
    .o_filament_two_sel(q[4]), .o_pirani_one_on(q[5]),
    .o_pirani_two_on(q[6]), .o_keypad_enabled(q[7]),
    .o_panel_enabled(q[8]), .o_remote_enabled(q[9]),
    .o_log_clear(q[10]), .o_key_auto(q[11]), .o_touch(q[12]));
  // ----
  // pulse counters and hang guard
  // ----
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    lcnt <= lcnt + (q[10] === 1'b1);
    kcnt <= kcnt + (q[11] === 1'b1);
    tcnt <= tcnt + (q[12] === 1'b1);
    if (cyc_n == 4000)
    begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  task chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // line change, then long enough for debounce and decode
  task set(input int b, input logic v);
    @(posedge clk) cl_r[b] <= v;
    repeat (16) @(posedge clk);
    #1;
  endtask
  task pu(input int b);
    @(posedge clk) pv_r[b] <= 1'b1;
    @(posedge clk) pv_r[b] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_gate;
    chk("state", q[9:0], 10'h1e8);
    set(0, 1'b1);
    chk("state", q[9:0], 10'h1e8);
    set(0, 1'b0);
    set(8, 1'b1);
    chk("state", q[9:0], 10'h3e8);
    @(posedge clk) cl_r[0] <= 1'b1;
    repeat (4) @(posedge clk);
    set(0, 1'b0);
    chk("state", q[9:0], 10'h3e8);
    $display("t_gate done");
  endtask
  task t_ion;
    @(posedge clk) ok_r[0] <= 1'b0;
    set(0, 1'b1);
    chk("state", q[9:0], 10'h3e8);
    set(0, 1'b0);
    @(posedge clk) ok_r[0] <= 1'b1;
    set(0, 1'b1);
    chk("state", q[9:0], 10'h3e9);
    set(1, 1'b1);
    chk("state", q[9:0], 10'h3ea);
    set(1, 1'b0);
    chk("state", q[9:0], 10'h3e8);
    set(0, 1'b0);
    $display("t_ion done");
  endtask
  task t_degas;
    set(0, 1'b1);
    set(2, 1'b1);
    chk("state", q[9:0], 10'h3ed);
    repeat (40) @(posedge clk);
    #1;
    chk("state", q[9:0], 10'h3e9);
    set(2, 1'b0);
    set(2, 1'b1);
    set(2, 1'b0);
    chk("state", q[9:0], 10'h3e9);
    set(3, 1'b1);
    pu(4);
    chk("state", q[9:0], 10'h3e8);
    set(3, 1'b0);
    pu(4);
    set(10, 1'b1);
    chk("state", q[9:0], 10'h3f9);
    set(10, 1'b0);
    set(9, 1'b1);
    set(9, 1'b0);
    chk("state", q[9:0], 10'h3e0);
    set(9, 1'b1);
    set(0, 1'b0);
    $display("t_degas done");
  endtask
  task t_misc;
    for (int b = 5; b < 7; b++)
    begin
      set(b, 1'b1);
      chk("state", q[9:0], 10'h3e8 & ~(10'h001 << b));
      set(b, 1'b0);
      chk("state", q[9:0], 10'h3e8);
    end
    set(7, 1'b1);
    set(7, 1'b0);
    chk("log", lcnt[9:0], 10'h001);
    pu(3);
    set(4, 1'b1);
    pu(3);
    chk("auto", kcnt[9:0], 10'h001);
    pu(6);
    set(11, 1'b1);
    pu(6);
    chk("touch", tcnt[9:0], 10'h001);
    chk("state", q[9:0], 10'h268);
    $display("t_misc done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    t_gate;
    t_ion;
    t_degas;
    t_misc;
    tally_and_finish;
  end
endmodule
`default_nettype wire
